// ===== shared/srw_pkg.sv
// Shared constants and types for the supervisory reset and watchdog block
package srw_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ = 20_000_000;
  // One millisecond in nanoseconds and in clock cycles
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned MS_TICK_CYCLES = MS_NS / CLK_NS;

  // Reset active timeout, in milliseconds: least, typical, longest
  localparam int unsigned RST_TIMEOUT_MIN_MS = 140;
  localparam int unsigned RST_TIMEOUT_MS = 200;
  localparam int unsigned RST_TIMEOUT_MAX_MS = 400;

  // Watchdog timeout in milliseconds
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;

  // Width of the shared millisecond timer
  localparam int unsigned TMR_W = 11;

  // Reset values of the output flops
  localparam logic RESET_N_RST = 1'h0;
  localparam logic RESET_HI_RST = 1'h1;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN = 3'b100
  } srw_state_t;

endpackage

// ===== rtl/srw_tick.sv
// Millisecond enable divider with phase restart
`timescale 1ns/1ps
module srw_tick
  import srw_pkg::*;
#(
  parameter int unsigned CYCLES = MS_TICK_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic clr, // Restart the divider phase
  output logic tick // One-cycle enable every CYCLES clocks
);

  localparam int unsigned CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // Next count and tick; clear restarts a full period
  always_comb begin
    if (clr || cnt_r == LAST) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
    tick_nxt = !clr && (cnt_r == LAST);
  end

  // Divider registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

// ===== rtl/srw_top.sv
// Supervisory reset generator with watchdog and manual reset
// Functional notes
// - Hold reset while supply is not good
// - After supply good, hold reset for timeout
// - Reset on watchdog silence; any edge restarts
// - Manual reset low asserts system reset
// - Undriven watchdog input disables the watchdog
// - Low-true push-pull reset output
// - Optional high-true complement output
// - Undriven manual reset reads as inactive
// - Reset timeout 140 to 400 ms, typ 200
`timescale 1ns/1ps
module srw_top
  import srw_pkg::*;
#(
  parameter bit HAS_MR = 1'b1, // 1: manual reset input, 0: dual outputs
  parameter int unsigned MS_CYCLES = MS_TICK_CYCLES, // Clocks per millisecond
  parameter int unsigned RST_MS = RST_TIMEOUT_MS, // Reset hold time in ms
  parameter int unsigned WD_MS = WDOG_TIMEOUT_MS // Watchdog timeout in ms
) (
  input wire logic CLOCK, // System clock, 20 MHz
  input wire logic RST, // Asynchronous reset, active high
  input wire logic SUPPLY_GOOD, // High while supply is above trip level
  input wire logic MANUAL_RESET_N, // Manual reset level, low asserts
  input wire logic MANUAL_RESET_N_DRIVEN, // High while something drives it
  input wire logic WATCHDOG_KICK_IN, // Watchdog input level
  input wire logic WATCHDOG_DRIVEN, // High while the watchdog input is driven
  output logic RESET_N_OUT, // System reset, low while asserted
  output logic RESET_OUT // System reset, high while asserted
);

  localparam logic [TMR_W-1:0] RST_LAST = TMR_W'(RST_MS - 1);
  localparam logic [TMR_W-1:0] WD_LAST = TMR_W'(WD_MS - 1);

  srw_state_t state_r;
  srw_state_t state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic kick_prev_r;
  logic rst_n_r;
  logic rst_n_nxt;
  logic rst_hi_r;
  logic rst_hi_nxt;
  logic ms_tick;
  logic tick_clr;
  logic mr_active;
  logic cause;
  logic wd_en;
  logic kick_edge;
  logic wd_expire;

  // Millisecond enable shared by the reset and watchdog timers
  srw_tick #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .clk(CLOCK),
    .rst(RST),
    .clr(tick_clr),
    .tick(ms_tick)
  );

  // Reset causes and watchdog qualifiers
  assign mr_active = HAS_MR && MANUAL_RESET_N_DRIVEN && !MANUAL_RESET_N;
  assign cause = !SUPPLY_GOOD || mr_active;
  assign wd_en = WATCHDOG_DRIVEN;
  assign kick_edge = wd_en && (WATCHDOG_KICK_IN != kick_prev_r);
  assign wd_expire = wd_en && ms_tick && (tmr_r == WD_LAST);

  // Sequencer next state and shared millisecond timer
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    case (state_r)
      ST_HOLD: begin
        tmr_nxt = '0;
        if (!cause) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cause) begin
          state_nxt = ST_HOLD;
          tmr_nxt = '0;
        end else if (ms_tick) begin
          if (tmr_r == RST_LAST) begin
            state_nxt = ST_RUN;
            tmr_nxt = '0;
          end else begin
            tmr_nxt = tmr_r + TMR_W'(1);
          end
        end
      end
      ST_RUN: begin
        if (cause) begin
          state_nxt = ST_HOLD;
          tmr_nxt = '0;
        end else if (wd_expire) begin
          state_nxt = ST_DELAY;
          tmr_nxt = '0;
        end else if (kick_edge || !wd_en) begin
          tmr_nxt = '0;
        end else if (ms_tick) begin
          tmr_nxt = tmr_r + TMR_W'(1);
        end
      end
      default: begin
        state_nxt = ST_HOLD;
        tmr_nxt = '0;
      end
    endcase
  end

  // Restart the millisecond phase so every timed wait is whole
  assign tick_clr = (state_nxt != state_r)
    || ((state_r == ST_RUN) && (kick_edge || !wd_en));

  // Output levels follow the next state so they change with it
  always_comb begin
    rst_n_nxt = (state_nxt == ST_RUN);
    rst_hi_nxt = HAS_MR ? 1'b0 : (state_nxt != ST_RUN);
  end

  // Sequencer, timer, watchdog sample and output registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r <= ST_HOLD;
      tmr_r <= '0;
      kick_prev_r <= 1'b0;
      rst_n_r <= RESET_N_RST;
      rst_hi_r <= HAS_MR ? 1'b0 : RESET_HI_RST;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      kick_prev_r <= WATCHDOG_KICK_IN;
      rst_n_r <= rst_n_nxt;
      rst_hi_r <= rst_hi_nxt;
    end
  end

  assign RESET_N_OUT = rst_n_r;
  assign RESET_OUT = rst_hi_r;

  // Checks on the sequencer and outputs
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  sequence s_release;
    $rose(RESET_N_OUT);
  endsequence

  sequence s_delay_done;
    $past(state_r) == ST_DELAY && $past(ms_tick) && $past(tmr_r) == RST_LAST;
  endsequence

  property p_supply_hold;
    !SUPPLY_GOOD |=> !RESET_N_OUT && state_r == ST_HOLD;
  endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("Reset not held while supply is low");

  property p_delay_full;
    s_release |-> s_delay_done;
  endproperty
  a_delay_full: assert property (p_delay_full)
    else $error("Reset released before full timeout");

  property p_timeout_range;
    RST_MS >= RST_TIMEOUT_MIN_MS && RST_MS <= RST_TIMEOUT_MAX_MS
      || MS_CYCLES != MS_TICK_CYCLES;
  endproperty
  a_timeout_range: assert property (p_timeout_range)
    else $error("Reset timeout outside allowed range");

  property p_kick_restart;
    state_r == ST_RUN && !cause && kick_edge && !wd_expire |=> tmr_r == '0;
  endproperty
  a_kick_restart: assert property (p_kick_restart)
    else $error("Watchdog edge did not restart timer");

  property p_wdog_fire;
    state_r == ST_RUN && !cause && wd_expire |=> state_r == ST_DELAY && !RESET_N_OUT;
  endproperty
  a_wdog_fire: assert property (p_wdog_fire)
    else $error("Watchdog timeout did not assert reset");

  property p_manual;
    HAS_MR && MANUAL_RESET_N_DRIVEN && !MANUAL_RESET_N |=> !RESET_N_OUT ##1 !RESET_N_OUT;
  endproperty
  a_manual: assert property (p_manual)
    else $error("Manual reset did not assert reset");

  property p_float_wdog;
    state_r == ST_RUN && !WATCHDOG_DRIVEN && !cause |=> RESET_N_OUT && tmr_r == '0;
  endproperty
  a_float_wdog: assert property (p_float_wdog)
    else $error("Watchdog acted while its input was undriven");

  property p_low_true;
    (state_r == ST_RUN) == RESET_N_OUT;
  endproperty
  a_low_true: assert property (p_low_true)
    else $error("Low-true output disagrees with state");

  property p_complement;
    HAS_MR ? !RESET_OUT : (RESET_OUT == !RESET_N_OUT);
  endproperty
  a_complement: assert property (p_complement)
    else $error("High-true output is not the complement");

  // An undriven or absent manual input must never pull a running system down
  property p_mr_float;
    (!MANUAL_RESET_N_DRIVEN || !HAS_MR) && SUPPLY_GOOD && state_r == ST_RUN && !wd_expire
      |=> RESET_N_OUT;
  endproperty
  a_mr_float: assert property (p_mr_float)
    else $error("Undriven or absent manual reset acted");

  property p_rearm;
    s_release |-> tmr_r == '0 && state_r == ST_RUN;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("Watchdog timing not restarted at release");

endmodule

// ===== test/srw_cpu_model.sv
// Processor model that drives the watchdog pin
`timescale 1ns/1ps
module srw_cpu_model (
  input wire logic clk, // System clock
  input wire logic drive_en, // Drive the watchdog pin when high
  input wire logic kick_en, // Toggle the pin when high
  input wire logic [7:0] gap, // Idle cycles between toggles
  output logic kick, // Watchdog pin level
  output logic driven // High while the pin is driven
);
  logic [7:0] cnt_r;
  logic lvl_r;
  initial begin
    cnt_r = 8'h00;
    lvl_r = 1'b0;
  end
  // Toggle the pin once every gap+1 cycles while kicking
  always @(negedge clk) begin
    cnt_r <= (cnt_r >= gap) ? 8'h00 : cnt_r + 8'h01;
    if (kick_en && cnt_r >= gap) lvl_r <= ~lvl_r;
  end
  // A released pin does not hold its last level
  assign kick = drive_en ? lvl_r : ~lvl_r;
  assign driven = drive_en;
endmodule

// ===== test/srw_tb_top.sv
// Self-checking bench for the supervisory reset block
`timescale 1ns/1ps
module srw_tb_top;
  import srw_pkg::*;
  localparam int unsigned MSC = 10;
  localparam int unsigned RMS = 4;
  localparam int unsigned WMS = 8;
  logic clk = 1'b0, rst = 1'b1, sup = 1'b0, mr_n = 1'b1, mr_drv = 1'b0;
  logic drv_en = 1'b1, kick_en = 1'b1;
  logic [7:0] gap = 8'h00;
  logic [7:0] g;
  wire kick, wd_drv, rn_a, r_a, rn_b, r_b;
  integer seed, error_cnt = 0, samples_checked = 0, n, i;
  // Clock at 20 MHz
  always #25 clk = ~clk;
  srw_cpu_model cpu_u (.clk(clk), .drive_en(drv_en), .kick_en(kick_en), .gap(gap),
    .kick(kick), .driven(wd_drv));
  srw_top #(.HAS_MR(1'b1), .MS_CYCLES(MSC), .RST_MS(RMS), .WD_MS(WMS)) dut_u (
    .CLOCK(clk), .RST(rst), .SUPPLY_GOOD(sup), .MANUAL_RESET_N(mr_n),
    .MANUAL_RESET_N_DRIVEN(mr_drv), .WATCHDOG_KICK_IN(kick), .WATCHDOG_DRIVEN(wd_drv),
    .RESET_N_OUT(rn_a), .RESET_OUT(r_a));
  srw_top #(.HAS_MR(1'b0), .MS_CYCLES(MSC), .RST_MS(RMS), .WD_MS(WMS)) dut_u2 (
    .CLOCK(clk), .RST(rst), .SUPPLY_GOOD(sup), .MANUAL_RESET_N(mr_n),
    .MANUAL_RESET_N_DRIVEN(mr_drv), .WATCHDOG_KICK_IN(kick), .WATCHDOG_DRIVEN(wd_drv),
    .RESET_N_OUT(rn_b), .RESET_OUT(r_b));
  // Delay n lies in the window of ms milliseconds plus pipeline slack
  function automatic logic in_win(int unsigned ms, integer cnt);
    return (cnt + 1 >= ms * MSC) && (cnt <= ms * MSC + 3);
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Count cycles until the low-true output reaches v, bounded
  task automatic wait_rn(logic v, output integer cnt);
    cnt = 0;
    while (rn_a !== v && cnt < 300) begin
      @(negedge clk);
      cnt = cnt + 1;
    end
    if (rn_a !== v) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  endtask
  // Reset output must stay released for a number of cycles
  task automatic hold_hi(int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(negedge clk);
      if (rn_a !== 1'b1) bad = 1'b1;
    end
    chk(bad, 1'b0);
  endtask
  initial begin
    seed = 69;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    // Supply low holds RESET_N_OUT asserted on both units and RESET_OUT on the dual-output one
    repeat (30) @(negedge clk);
    chk(rn_a, 1'b0);
    chk({rn_b, r_b}, 2'b01);
    sup = 1'b1;
    wait_rn(1'b1, n);
    chk(in_win(RMS, n), 1'b1);
    @(negedge clk);
    chk({rn_b, r_b, r_a}, 3'b100);
    // Random kick spacing keeps the system running
    for (i = 0; i < 20; i++) begin
      g = 8'($unsigned($random(seed)) % 60);
      gap <= g;
      hold_hi(g + 2);
    end
    // Back-to-back toggles, then silence; model controls change without racing the model
    gap <= 8'h00;
    repeat (5) @(negedge clk);
    kick_en <= 1'b0;
    wait_rn(1'b0, n);
    chk(in_win(WMS, n), 1'b1);
    kick_en <= 1'b1;
    wait_rn(1'b1, n);
    chk(in_win(RMS, n), 1'b1);
    hold_hi(150);
    // Undriven and silent watchdog pin never trips
    drv_en = 1'b0;
    kick_en <= 1'b0;
    hold_hi(200);
    // Floating manual input is inactive
    mr_n = 1'b0;
    hold_hi(20);
    mr_drv = 1'b1;
    repeat (2) @(negedge clk);
    chk({rn_a, rn_b}, 2'b01);
    mr_n = 1'b1;
    wait_rn(1'b1, n);
    chk(in_win(RMS, n), 1'b1);
    // Supply drop in mid-run
    sup = 1'b0;
    repeat (2) @(negedge clk);
    chk({rn_a, r_b}, 2'b01);
    sup = 1'b1;
    wait_rn(1'b1, n);
    chk(in_win(RMS, n), 1'b1);
    // Block reset in mid-run asserts RESET_N_OUT on both units and RESET_OUT on the dual-output one, then a full timeout follows
    rst = 1'b1;
    @(negedge clk);
    chk({rn_a, r_a, rn_b, r_b}, 4'b0001);
    rst = 1'b0;
    wait_rn(1'b1, n);
    chk(in_win(RMS, n), 1'b1);
    chk({rn_b, r_b, r_a}, 3'b100);
    close_out;
  end
endmodule
